/* pchr_params.svh */
`ifndef PCHR_PARAMS_SVH
`define PCHR_PARAMS_SVH
// Function
// [R01] Status reads normal, writes only clear flags.
// [R02] Bit 15 sets on any parity error.
// [R03] Bit 14 sets on system error, write-one clears.
// [R04] Bit 13 sets on master abort, write-one clears.
// [R05] Bit 12 sets on received target abort.
// [R06] Bit 11 sets on signalled target abort.
// [R07] Medium select timing; select two clocks later.
// [R08] Bit 8 needs parity pin, mastership, response enable.
// [R09] Bit 7 follows fast back-to-back option only.
// [R10] Bits 6 and 5 read zero always.
// [R11] Bit 4 follows power-management option only.
// [R12] Class bytes read 00h, 00h, 02h.
// [R13] Line size, header, self-test read zero.
// [R14] Latency timer counts from master frame start.
// [R15] Expired timer ends burst when grant drops.
// [R16] Latency register read/write, resets to zero.
// [R17] I/O base keeps bits 31-7, 128 bytes.
// [R18] I/O base bit 0 reads one.
// [R19] Memory base keeps bits 31-7, low zero.
// [R20] Software programs memory base before memory access.
// [R21] Subsystem codes from EEPROM, else defaults.
// [R22] Read-only revision byte reports controller revision.
// [R23] Response enable gates parity pin drive, sampling.
// [R24] Reserved status and I/O bits read zero.

// =============================================================
// Configuration offsets (byte addresses of dwords).
`define PCHR_OFS_ID 8'h00
`define PCHR_OFS_CMD_STS 8'h04
`define PCHR_OFS_CLASS 8'h08
`define PCHR_OFS_MISC 8'h0C
`define PCHR_OFS_IO_BASE 8'h10
`define PCHR_OFS_MEM_BASE 8'h14
`define PCHR_OFS_SUBSYS 8'h2C

// =============================================================
// Field layouts and fixed values.
`define PCHR_STS_W1C_MASK 16'hF900
`define PCHR_BIT_PAR_SEEN 15
`define PCHR_BIT_SYS_ERR 14
`define PCHR_BIT_MABT_RCV 13
`define PCHR_BIT_TABT_RCV 12
`define PCHR_BIT_TABT_SIG 11
`define PCHR_BIT_DPD 8
`define PCHR_SEL_TIMING_MEDIUM 2'h1
`define PCHR_PROG_IF 8'h00
`define PCHR_SUBCLASS 8'h00
`define PCHR_BASECLASS 8'h02
`define PCHR_CMD_RESP_BIT 6
`define PCHR_BASE_LSB 7
`define PCHR_IO_LOW_BITS 7'h01
`define PCHR_MEM_LOW_BITS 7'h00
`define PCHR_LAT_RESET 8'h00
`define PCHR_SEL_DELAY 2
`endif

/* pchr_pkg.sv */
package pchr_pkg;
    // Latency timer state.
    typedef struct packed {
        logic [7:0] count;
        logic running;
        logic expired;
    } pchr_lat_state_s;

    // Configuration header state.
    typedef struct packed {
        logic [15:0] flags;
        logic resp_en;
        logic [7:0] lat_value;
        logic [24:0] io_base;
        logic [24:0] mem_base;
        logic [15:0] subsystem_vendor_code;
        logic [15:0] subsystem_code;
        logic [31:0] rdata;
        logic rvalid;
        logic perr_drive;
        logic [1:0] sel_pipe;
        logic devsel;
        logic burst_end;
    } pchr_state_s;
endpackage

/* pchr_lat_timer.sv */
`include "pchr_params.svh"

module pchr_lat_timer import pchr_pkg::*; #(
    parameter int LT_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic frame_start,
    input wire logic frame_active,
    input wire logic [7:0] lat_value,
    output logic expired
);
    // =============================================================
    // Elaboration check.
    if (LT_W != 8) begin : g_bad_width
        $error("pchr_lat_timer supports an 8-bit latency value only.");
    end

    pchr_lat_state_s st_r;
    pchr_lat_state_s st_nxt;

    // =============================================================
    // Counts clocks from the master frame start; a released frame discards it.
    always_comb begin
        st_nxt = st_r;
        if (frame_start) begin
            st_nxt.count = 8'h00; // R14
            st_nxt.running = 1'b1;
            st_nxt.expired = (lat_value == 8'h00);
        end else if (!frame_active) begin
            st_nxt.running = 1'b0; // R14
            st_nxt.expired = 1'b0;
        end else if (st_r.running && !st_r.expired) begin
            st_nxt.count = st_r.count + 8'h01;
            st_nxt.expired = ((st_r.count + 8'h01) >= lat_value); // R14
        end
    end

    // State register.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign expired = st_r.expired;

    // =============================================================
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    frame_drop_clears_a: assert property (!frame_active && !frame_start |=> !expired) // R14
        else $error("Latency expiry survived a released frame.");
    zero_lat_expires_a: assert property (frame_start && lat_value == 8'h00 |=> expired) // R14
        else $error("Zero latency did not expire at once.");
endmodule // pchr_lat_timer

/* pchr_regs.sv */
`include "pchr_params.svh"

module pchr_regs import pchr_pkg::*; #(
    parameter logic [7:0] REVISION = 8'h01, // Arbitrary value.
    parameter logic [15:0] DEF_SUBSYSTEM_VENDOR_CODE = 16'h1A2B, // Arbitrary value.
    parameter logic [15:0] DEF_SUBSYSTEM_CODE = 16'h3C4D, // Arbitrary value.
    parameter int LT_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic fast_b2b_option,
    input wire logic pm_option,
    input wire logic par_err_evt,
    input wire logic serr_evt,
    input wire logic master_abort_evt,
    input wire logic target_abort_rcv_evt,
    input wire logic target_abort_sig_evt,
    input wire logic tgt_data_par_err,
    input wire logic perr_sensed,
    input wire logic master_op,
    input wire logic tgt_frame_evt,
    input wire logic tgt_end,
    input wire logic mst_frame_start,
    input wire logic mst_frame_active,
    input wire logic gnt_n,
    input wire logic ee_done,
    input wire logic ee_present,
    input wire logic [15:0] ee_subsystem_vendor_code,
    input wire logic [15:0] ee_subsystem_code,
    output logic parity_response_enable,
    output logic perr_drive,
    output logic devsel_assert,
    output logic burst_end_req
);
    // =============================================================
    // Elaboration check.
    if (LT_W != 8) begin : g_bad_width
        $error("pchr_regs supports an 8-bit latency register only.");
    end

    // Decoding used by both the read and write paths.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr[7:2] == ofs[7:2]);
    endfunction

    pchr_state_s st_r;
    pchr_state_s st_nxt;
    logic lat_expired;
    logic [15:0] sts_read;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic dpd_cond;

    // =============================================================
    // Latency timer for master bursts.
    pchr_lat_timer #(
        .LT_W(LT_W)
    ) u_lat (
        .clk_sys(clk_sys),
        .reset(reset),
        .frame_start(mst_frame_start),
        .frame_active(mst_frame_active),
        .lat_value(st_r.lat_value),
        .expired(lat_expired)
    );

    // =============================================================
    // Status read image and flag events.
    always_comb begin
        sts_read = st_r.flags & `PCHR_STS_W1C_MASK; // R01
        sts_read[10:9] = `PCHR_SEL_TIMING_MEDIUM; // R07
        sts_read[7] = fast_b2b_option; // R09
        sts_read[6] = 1'b0; // R10
        sts_read[5] = 1'b0; // R10
        sts_read[4] = pm_option; // R11
        sts_read[3:0] = 4'h0; // R24
        dpd_cond = (tgt_data_par_err || perr_sensed) && master_op && st_r.resp_en; // R08
        set_vec = 16'h0000;
        set_vec[`PCHR_BIT_PAR_SEEN] = par_err_evt; // R02
        set_vec[`PCHR_BIT_SYS_ERR] = serr_evt; // R03
        set_vec[`PCHR_BIT_MABT_RCV] = master_abort_evt; // R04
        set_vec[`PCHR_BIT_TABT_RCV] = target_abort_rcv_evt; // R05
        set_vec[`PCHR_BIT_TABT_SIG] = target_abort_sig_evt; // R06
        set_vec[`PCHR_BIT_DPD] = dpd_cond; // R08
        clr_vec = 16'h0000;
        if (cfg_wr && hit(cfg_addr, `PCHR_OFS_CMD_STS)) begin
            clr_vec[15:8] = cfg_be[3] ? cfg_wdata[31:24] : 8'h00;
            clr_vec[7:0] = cfg_be[2] ? cfg_wdata[23:16] : 8'h00;
            clr_vec = clr_vec & `PCHR_STS_W1C_MASK; // R01
        end
    end

    // =============================================================
    // Next-state logic: register writes, reads, pins and burst end.
    always_comb begin
        st_nxt = st_r;
        // Sets win over a clear in the same cycle.
        st_nxt.flags = ((st_r.flags & ~clr_vec) | set_vec) & `PCHR_STS_W1C_MASK; // R01

        if (cfg_wr) begin
            if (hit(cfg_addr, `PCHR_OFS_CMD_STS) && cfg_be[0]) begin
                st_nxt.resp_en = cfg_wdata[`PCHR_CMD_RESP_BIT];
            end
            if (hit(cfg_addr, `PCHR_OFS_MISC) && cfg_be[1]) begin
                st_nxt.lat_value = cfg_wdata[15:8]; // R16
            end
            if (hit(cfg_addr, `PCHR_OFS_IO_BASE)) begin
                if (cfg_be[3]) st_nxt.io_base[24:17] = cfg_wdata[31:24]; // R17
                if (cfg_be[2]) st_nxt.io_base[16:9] = cfg_wdata[23:16];
                if (cfg_be[1]) st_nxt.io_base[8:1] = cfg_wdata[15:8];
                if (cfg_be[0]) st_nxt.io_base[0] = cfg_wdata[`PCHR_BASE_LSB];
            end
            if (hit(cfg_addr, `PCHR_OFS_MEM_BASE)) begin
                if (cfg_be[3]) st_nxt.mem_base[24:17] = cfg_wdata[31:24]; // R19
                if (cfg_be[2]) st_nxt.mem_base[16:9] = cfg_wdata[23:16];
                if (cfg_be[1]) st_nxt.mem_base[8:1] = cfg_wdata[15:8];
                if (cfg_be[0]) st_nxt.mem_base[0] = cfg_wdata[`PCHR_BASE_LSB];
            end
        end

        // Subsystem codes replace the defaults once the EEPROM is read.
        if (ee_done && ee_present) begin
            st_nxt.subsystem_vendor_code = ee_subsystem_vendor_code; // R21
            st_nxt.subsystem_code = ee_subsystem_code; // R21
        end

        // Read data is registered and valid for one cycle.
        st_nxt.rvalid = cfg_rd;
        st_nxt.rdata = 32'h0000_0000;
        if (cfg_rd) begin
            unique case (1'b1)
                hit(cfg_addr, `PCHR_OFS_CMD_STS): begin
                    st_nxt.rdata = {sts_read, 9'h000, st_r.resp_en, 6'h00}; // R01
                end
                hit(cfg_addr, `PCHR_OFS_CLASS): begin
                    st_nxt.rdata = {`PCHR_BASECLASS, `PCHR_SUBCLASS, `PCHR_PROG_IF,
                                    REVISION}; // R12 R22
                end
                hit(cfg_addr, `PCHR_OFS_MISC): begin
                    st_nxt.rdata = {16'h0000, st_r.lat_value, 8'h00}; // R13 R16
                end
                hit(cfg_addr, `PCHR_OFS_IO_BASE): begin
                    st_nxt.rdata = {st_r.io_base, `PCHR_IO_LOW_BITS}; // R17 R18 R24
                end
                hit(cfg_addr, `PCHR_OFS_MEM_BASE): begin
                    st_nxt.rdata = {st_r.mem_base, `PCHR_MEM_LOW_BITS}; // R19
                end
                hit(cfg_addr, `PCHR_OFS_SUBSYS): begin
                    st_nxt.rdata = {st_r.subsystem_code, st_r.subsystem_vendor_code}; // R21
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Parity pin is driven on target data errors only when enabled.
        st_nxt.perr_drive = tgt_data_par_err && st_r.resp_en && !master_op; // R23

        // Device select follows the target frame by two clocks.
        st_nxt.sel_pipe = {st_r.sel_pipe[0], tgt_frame_evt}; // R07
        if (tgt_end) begin
            st_nxt.devsel = 1'b0;
        end else if (st_r.sel_pipe[0]) begin
            st_nxt.devsel = 1'b1; // R07
        end

        // An expired timer ends the burst once grant is removed.
        st_nxt.burst_end = lat_expired && mst_frame_active && gnt_n; // R15
    end

    // =============================================================
    // State register.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.lat_value <= `PCHR_LAT_RESET; // R16
            st_r.subsystem_vendor_code <= DEF_SUBSYSTEM_VENDOR_CODE; // R21
            st_r.subsystem_code <= DEF_SUBSYSTEM_CODE; // R21
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign cfg_rdata = st_r.rdata;
    assign cfg_rvalid = st_r.rvalid;
    assign parity_response_enable = st_r.resp_en;
    assign perr_drive = st_r.perr_drive;
    assign devsel_assert = st_r.devsel;
    assign burst_end_req = st_r.burst_end;

    // =============================================================
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    par_flag_set_a: assert property (par_err_evt |=> st_r.flags[15]) // R02
        else $error("Parity error did not set bit 15.");
    sys_err_set_a: assert property (serr_evt |=> st_r.flags[14]) // R03
        else $error("System error did not set bit 14.");
    mabt_flag_set_a: assert property (master_abort_evt |=> st_r.flags[13]) // R04
        else $error("Master abort did not set bit 13.");
    tabt_rcv_set_a: assert property (target_abort_rcv_evt |=> st_r.flags[12]) // R05
        else $error("Received target abort did not set bit 12.");
    tabt_sig_set_a: assert property (target_abort_sig_evt |=> st_r.flags[11]) // R06
        else $error("Signalled target abort did not set bit 11.");
    no_write_set_a: assert property ($rose(st_r.flags[14]) |-> $past(serr_evt)) // R01
        else $error("Status flag rose without an event.");
    devsel_timing_a: assert property (
        tgt_frame_evt ##1 !tgt_end [*2] |-> devsel_assert) // R07
        else $error("Device select not asserted two clocks after frame.");
    dpd_cause_a: assert property ($rose(st_r.flags[8]) |-> $past(dpd_cond)) // R08
        else $error("Bit 8 set without its three conditions.");
    status_fixed_a: assert property (
        cfg_rd && hit(cfg_addr, `PCHR_OFS_CMD_STS) ##1 1'b1 |->
        cfg_rdata[26:25] == 2'h1 && cfg_rdata[22:21] == 2'h0
        && cfg_rdata[23] == $past(fast_b2b_option)) // R07 R09 R10
        else $error("Status fixed bits read wrong.");
    io_low_bits_a: assert property (
        cfg_rd && hit(cfg_addr, `PCHR_OFS_IO_BASE) |=> cfg_rdata[6:0] == 7'h01) // R17 R18
        else $error("I/O base low bits read wrong.");
    stub_zero_a: assert property (
        cfg_rd && hit(cfg_addr, `PCHR_OFS_MISC) |=>
        cfg_rdata[7:0] == 8'h00 && cfg_rdata[31:16] == 16'h0000) // R13
        else $error("Stub registers read nonzero.");
    perr_gate_a: assert property (!st_r.resp_en |=> !perr_drive) // R23
        else $error("Parity pin driven while response disabled.");
    burst_end_a: assert property (
        lat_expired && mst_frame_active && gnt_n |=> burst_end_req) // R15
        else $error("Burst end not requested after expiry.");

    cover_clear_c: cover property (st_r.flags[14] ##1 !st_r.flags[14]);
    cover_devsel_c: cover property (tgt_frame_evt ##2 devsel_assert);
    cover_burst_c: cover property (burst_end_req);
    cover_eeprom_c: cover property (ee_done && ee_present);
endmodule // pchr_regs

/* pchr_host_model.sv */
// =============================================================
// Configuration master standing in for the host bridge.
module pchr_host_model (
    input wire logic clk_sys,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid,
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus before the first request.
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end

    // One read; the answer is taken in the cycle after the request edge.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
        @(posedge clk_sys);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk_sys);
        cfg_rd <= 1'b0;
        cfg_addr <= ~a; // Released lines show the inverse.
        @(negedge clk_sys);
        d = cfg_rdata;
        v = cfg_rvalid;
    endtask

    // One write; it takes effect at the request edge.
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
        cfg_addr <= ~a;
        cfg_be <= ~be;
        cfg_wdata <= ~d;
    endtask
endmodule // pchr_host_model

/* pci_config_header_regs_tb.sv */
// =============================================================
// Self-checking bench for the configuration header.
module pci_config_header_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset, fb, pm, mop, mfa, gnt_n, ee_pres;
    logic [10:0] pls;
    logic cfg_rd, cfg_wr, cfg_rvalid, pre, perr_drive, devsel, bend;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    int miscompares, total_checks, n;

    pchr_host_model host (.clk_sys(clk_sys), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata));

    pchr_regs dut (.clk_sys(clk_sys), .reset(reset), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .fast_b2b_option(fb), .pm_option(pm), .par_err_evt(pls[0]),
        .serr_evt(pls[1]), .master_abort_evt(pls[2]), .target_abort_rcv_evt(pls[3]),
        .target_abort_sig_evt(pls[4]), .tgt_data_par_err(pls[5]), .perr_sensed(pls[6]),
        .master_op(mop), .tgt_frame_evt(pls[7]), .tgt_end(pls[8]), .mst_frame_start(pls[9]),
        .mst_frame_active(mfa), .gnt_n(gnt_n), .ee_done(pls[10]), .ee_present(ee_pres),
        .ee_subsystem_vendor_code(16'h5A5A), .ee_subsystem_code(16'hA5A5), .parity_response_enable(pre),
        .perr_drive(perr_drive), .devsel_assert(devsel), .burst_end_req(bend));

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Reads one dword and compares valid flag and data.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic v;
        host.rd(a, d, v);
        check(v, 1, "read valid");
        check(d, exp, "read data");
    endtask

    // One-cycle pulse on the chosen inputs; returns in the following cycle.
    task automatic pulse(input logic [10:0] p);
        @(posedge clk_sys);
        pls <= p;
        @(posedge clk_sys);
        pls <= 11'h000;
        @(negedge clk_sys);
    endtask

    // Reset values of every mapped dword and an unmapped one.
    task automatic t_reset();
        rd_chk(8'h08, 32'h0200_0001);
        rd_chk(8'h0C, 32'h0);
        rd_chk(8'h10, 32'h1);
        rd_chk(8'h14, 32'h0);
        rd_chk(8'h2C, 32'h3C4D_1A2B);
        rd_chk(8'h04, 32'h0200_0000);
        rd_chk(8'h20, 32'h0);
    endtask

    // All-ones writes leave only writable fields changed.
    task automatic t_rw();
        host.wr(8'h04, 4'hF, 32'hFFFF_FFFF);
        host.wr(8'h08, 4'hF, 32'hFFFF_FFFF);
        host.wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
        host.wr(8'h10, 4'hF, 32'hFFFF_FFFF);
        host.wr(8'h14, 4'hF, 32'hFFFF_FFFF);
        host.wr(8'h2C, 4'hF, 32'hFFFF_FFFF);
        rd_chk(8'h08, 32'h0200_0001);
        rd_chk(8'h0C, 32'h0000_FF00);
        rd_chk(8'h10, 32'hFFFF_FF81);
        rd_chk(8'h14, 32'hFFFF_FF80);
        rd_chk(8'h2C, 32'h3C4D_1A2B);
        rd_chk(8'h04, 32'h0200_0040);
        check(pre, 1, "response enable");
        @(posedge clk_sys);
        fb <= 1'b1;
        rd_chk(8'h04, 32'h0280_0040);
        @(posedge clk_sys);
        pm <= 1'b1;
        rd_chk(8'h04, 32'h0290_0040);
        @(posedge clk_sys);
        fb <= 1'b0;
        pm <= 1'b0;
    endtask

    // Each event sets its flag; a zero write keeps it, a one write clears it.
    task automatic t_flags();
        logic [15:0] b;
        for (int k = 0; k < 5; k++) begin
            b = 16'h8000 >> k;
            pulse(11'h001 << k);
            rd_chk(8'h04, {16'h0200 | b, 16'h0040});
            host.wr(8'h04, 4'hC, 32'h0);
            rd_chk(8'h04, {16'h0200 | b, 16'h0040});
            host.wr(8'h04, 4'hC, {b, 16'h0000});
            rd_chk(8'h04, 32'h0200_0040);
        end
    endtask

    // Bit 8 conditions and the parity pin drive.
    task automatic t_parity();
        @(posedge clk_sys);
        mop <= 1'b1;
        pulse(11'h020);
        rd_chk(8'h04, 32'h0300_0040);
        host.wr(8'h04, 4'hC, 32'h0100_0000);
        @(posedge clk_sys);
        mop <= 1'b0;
        pulse(11'h020);
        check(perr_drive, 1, "parity drive");
        rd_chk(8'h04, 32'h0200_0040);
        host.wr(8'h04, 4'h1, 32'h0);
        pulse(11'h020);
        check(perr_drive, 0, "parity drive off");
        @(posedge clk_sys);
        mop <= 1'b1;
        pulse(11'h040);
        rd_chk(8'h04, 32'h0200_0000);
        // Any parity error sets bit 15 even with response disabled.
        pulse(11'h001);
        rd_chk(8'h04, 32'h8200_0000);
        host.wr(8'h04, 4'hC, 32'h8000_0000);
        rd_chk(8'h04, 32'h0200_0000);
    endtask

    // Select is driven two clocks after the frame and dropped on target end.
    task automatic t_devsel();
        pulse(11'h080);
        check(devsel, 0, "select early");
        @(negedge clk_sys);
        check(devsel, 1, "select on time");
        repeat (3) @(negedge clk_sys);
        check(devsel, 1, "select held");
        pulse(11'h100);
        check(devsel, 0, "select dropped");
    endtask

    // Latency timer expiry, grant gating and early frame drop.
    task automatic t_lat();
        host.wr(8'h0C, 4'h2, 32'h0000_0400);
        rd_chk(8'h0C, 32'h0000_0400);
        @(posedge clk_sys);
        mfa <= 1'b1;
        pulse(11'h200);
        n = 1;
        while (bend !== 1'b1 && n < 12) begin
            @(negedge clk_sys);
            n++;
        end
        check(n, 6, "expiry time");
        @(posedge clk_sys);
        gnt_n <= 1'b0;
        repeat (2) @(negedge clk_sys);
        check(bend, 0, "grant held");
        @(posedge clk_sys);
        gnt_n <= 1'b1;
        repeat (2) @(negedge clk_sys);
        check(bend, 1, "grant dropped");
        @(posedge clk_sys);
        mfa <= 1'b0;
        repeat (2) @(negedge clk_sys);
        check(bend, 0, "frame over");
        @(posedge clk_sys);
        mfa <= 1'b1;
        pulse(11'h200);
        @(posedge clk_sys);
        mfa <= 1'b0;
        // Frame comes back without a new start: the dropped count must stay discarded.
        @(posedge clk_sys);
        mfa <= 1'b1;
        repeat (8) @(negedge clk_sys);
        check(bend, 0, "short frame");
        @(posedge clk_sys);
        mfa <= 1'b0;
    endtask

    // Subsystem codes: defaults without a memory, loaded words with one.
    task automatic t_ee();
        pulse(11'h400);
        rd_chk(8'h2C, 32'h3C4D_1A2B);
        @(posedge clk_sys);
        ee_pres <= 1'b1;
        pulse(11'h400);
        rd_chk(8'h2C, 32'hA5A5_5A5A);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Clock at 8 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Watchdog cuts a hang short.
    initial begin
        #200000;
        miscompares++;
        conclude();
    end

    // Main sequence; the memory base is programmed before any memory access.
    initial begin
        reset = 1'b1;
        fb = 1'b0;
        pm = 1'b0;
        mop = 1'b0;
        mfa = 1'b0;
        gnt_n = 1'b1;
        ee_pres = 1'b0;
        pls = 11'h000;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        t_rw();
        t_flags();
        t_parity();
        t_devsel();
        t_lat();
        t_ee();
        conclude();
    end
endmodule // pci_config_header_regs_tb
